// file: src/ind_load_pkg.sv
// Purpose: constants for the indirect accumulator load unit
// Assumes: 16-bit pointers, 8-bit data, 6-bit signed offset literal
// Notes: shared by the load unit and its address former
// Summary of operation
// - The access address is pointer plus one, pointer minus one, the pointer itself (post modes), or pointer plus the signed offset.
// - After the move the pointer is one up for increments, one down for decrements, same for offset.
// - The byte read through the window goes into the accumulator.
// - The window registers hold no storage; they only redirect the access.
// - A window access really reaches the location named by its pointer.
// - Each pointer is a 16-bit value and its arithmetic wraps within 16 bits.
package ind_load_pkg;
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int OFS_W = 6;
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_DONE} load_state_t;
endpackage

// file: src/ind_addr_former.sv
// Purpose: forms access address and written-back pointer
// Assumes: combinational, used once per instruction
// Notes: wraps within 16 bits
`timescale 1ns/1ps
module ind_addr_former (
  // Operation select
  input wire logic i_use_offset,
  input wire logic [1:0] i_pointer_update_mode,
  input wire logic [5:0] i_offset,
  // Pointer in
  input wire logic [15:0] i_ptr,
  // Results
  output logic [15:0] o_addr,
  output logic [15:0] o_ptr_next
);
  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ofs_ext;
  assign ptr_inc = i_ptr + ind_load_pkg::PTR_ONE;
  assign ptr_dec = i_ptr - ind_load_pkg::PTR_ONE;
  assign ofs_ext = {{10{i_offset[5]}}, i_offset};
  always_comb begin
    o_addr = i_ptr;
    o_ptr_next = i_ptr;
    if (i_use_offset) begin
      o_addr = i_ptr + ofs_ext;
    end else begin
      case (i_pointer_update_mode)
        ind_load_pkg::MODE_PRE_INC: begin
          o_addr = ptr_inc;
          o_ptr_next = ptr_inc;
        end
        ind_load_pkg::MODE_PRE_DEC: begin
          o_addr = ptr_dec;
          o_ptr_next = ptr_dec;
        end
        ind_load_pkg::MODE_POST_INC: begin
          o_ptr_next = ptr_inc;
        end
        ind_load_pkg::MODE_POST_DEC: begin
          o_ptr_next = ptr_dec;
        end
        default: begin
          o_ptr_next = i_ptr;
        end
      endcase
    end
  end
endmodule

// file: src/load_accumulator_indirect.sv
// Purpose: executes the indirect accumulator load with pointer update
// Assumes: data memory answers a read request in its first cycle or any later cycle
// Notes: two pointers, selected per instruction
`timescale 1ns/1ps
module load_accumulator_indirect (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Instruction
  input wire logic i_start,
  input wire logic i_ptr_sel,
  input wire logic i_use_offset,
  input wire logic [1:0] i_pointer_update_mode,
  input wire logic [5:0] i_offset,
  // Pointer load from core
  input wire logic i_ptr_wr,
  input wire logic i_ptr_wr_sel,
  input wire logic [15:0] i_ptr_wr_data,
  // Data memory
  output logic o_mem_rd,
  output logic [15:0] o_mem_addr,
  input wire logic i_mem_valid,
  input wire logic [7:0] i_mem_rdata,
  // Results
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_accumulator,
  output logic [15:0] o_indirect_pointer0,
  output logic [15:0] o_indirect_pointer1
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ind_load_pkg::load_state_t state_ff;
  ind_load_pkg::load_state_t nxt_state;
  logic [15:0] indirect_pointer_ff [2];
  logic [15:0] addr_ff;
  logic [15:0] ptr_upd_ff;
  logic sel_ff;
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;

  // ----------------------------------------
  // Combinational nets
  // ----------------------------------------
  logic st_idle;
  logic st_read;
  logic st_done;
  logic take;
  logic load_done;
  logic [15:0] sel_ptr;
  logic [15:0] nxt_addr;
  logic [15:0] nxt_ptr;
  logic [1:0] ptr_upd_en;
  logic [1:0] ptr_load_en;

  // ----------------------------------------
  // Status decode
  // ----------------------------------------
  assign st_idle = (state_ff == ind_load_pkg::ST_IDLE);
  assign st_read = (state_ff == ind_load_pkg::ST_READ);
  assign st_done = (state_ff == ind_load_pkg::ST_DONE);

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Start honoured only while idle
  assign take = i_start && st_idle;
  // Read data taken only while the request stands
  assign load_done = st_read && i_mem_valid;

  // ----------------------------------------
  // Operand pointer
  // ----------------------------------------
  // Pointer named by the instruction, as it stands at start
  assign sel_ptr = i_ptr_sel ? indirect_pointer_ff[1] : indirect_pointer_ff[0];

  // ----------------------------------------
  // Address forming
  // ----------------------------------------
  ind_addr_former u_addr (
    .i_use_offset(i_use_offset),
    .i_pointer_update_mode(i_pointer_update_mode),
    .i_offset(i_offset),
    .i_ptr(sel_ptr),
    .o_addr(nxt_addr),
    .o_ptr_next(nxt_ptr)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ind_load_pkg::ST_IDLE: begin
        if (take) begin
          nxt_state = ind_load_pkg::ST_READ;
        end
      end
      ind_load_pkg::ST_READ: begin
        if (i_mem_valid) begin
          nxt_state = ind_load_pkg::ST_DONE;
        end
      end
      ind_load_pkg::ST_DONE: begin
        nxt_state = ind_load_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = ind_load_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ind_load_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Access address
  // ----------------------------------------
  // Held for the whole read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_ff <= ind_load_pkg::PTR_RESET;
    end else if (take) begin
      addr_ff <= nxt_addr;
    end
  end

  // ----------------------------------------
  // Written-back pointer value
  // ----------------------------------------
  // Formed at start, applied when the data arrives
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_upd_ff <= ind_load_pkg::PTR_RESET;
    end else if (take) begin
      ptr_upd_ff <= nxt_ptr;
    end
  end

  // ----------------------------------------
  // Pointer select capture
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_ff <= 1'b0;
    end else if (take) begin
      sel_ff <= i_ptr_sel;
    end
  end

  // ----------------------------------------
  // Indirect pointers
  // ----------------------------------------
  // Core loads are ignored while an instruction runs
  generate
    for (genvar gi = 0; gi < 2; gi++) begin : g_ptr
      logic [15:0] nxt_pointer;
      assign ptr_upd_en[gi] = load_done && (sel_ff == 1'(gi));
      assign ptr_load_en[gi] = i_ptr_wr && (i_ptr_wr_sel == 1'(gi)) && st_idle;
      // Write-back wins over a core load
      always_comb begin
        nxt_pointer = indirect_pointer_ff[gi];
        if (ptr_upd_en[gi]) begin
          nxt_pointer = ptr_upd_ff;
        end else if (ptr_load_en[gi]) begin
          nxt_pointer = i_ptr_wr_data;
        end
      end
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          indirect_pointer_ff[gi] <= ind_load_pkg::PTR_RESET;
        end else begin
          indirect_pointer_ff[gi] <= nxt_pointer;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  // Windows hold no storage; the byte lands here
  always_comb begin
    nxt_acc = acc_ff;
    if (load_done) begin
      nxt_acc = i_mem_rdata;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= ind_load_pkg::ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // ----------------------------------------
  // Read request
  // ----------------------------------------
  // Request stands until the data arrives
  assign o_mem_rd = st_read;
  assign o_mem_addr = addr_ff;

  // ----------------------------------------
  // Status and results
  // ----------------------------------------
  assign o_busy = !st_idle;
  assign o_done = st_done;
  assign o_accumulator = acc_ff;
  assign o_indirect_pointer0 = indirect_pointer_ff[0];
  assign o_indirect_pointer1 = indirect_pointer_ff[1];
endmodule

// file: test/ind_load_chk_sva.sv
// Purpose: assertions on the ports of the indirect load unit
// Assumes: one clock, asynchronous active-low reset
// Notes: address checks follow pointer 0 only
`timescale 1ns/1ps
module ind_load_chk (
  // Watched ports
  input logic i_clk_sys, i_rst_n, i_start, i_ptr_sel, i_use_offset, i_mem_valid,
  input logic o_busy, o_mem_rd, o_done,
  input logic [1:0] i_pointer_update_mode,
  input logic [7:0] i_mem_rdata, o_accumulator,
  input logic [15:0] o_mem_addr, o_indirect_pointer0
);
  wire st = i_start && !o_busy, go = st && !i_ptr_sel && !i_use_offset;
  wire rx = o_mem_rd && i_mem_valid;
  wire [1:0] md = i_pointer_update_mode;
  wire [15:0] a = o_mem_addr, p = o_indirect_pointer0;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_read_req: assert property (st |=> o_mem_rd) else $error("no read");
  a_pre_inc: assert property (go && md == 2'h0 |=> a == $past(p) + 16'h0001)
    else $error("inc addr");
  a_pre_dec: assert property (go && md == 2'h1 |=> a == $past(p) - 16'h0001)
    else $error("dec addr");
  a_post_addr: assert property (go && md[1] |=> a == $past(p)) else $error("post addr");
  a_ptr_hold: assert property (o_mem_rd && !i_mem_valid |=> $stable(p))
    else $error("ptr moved");
  a_acc_load: assert property (rx |=> o_accumulator == $past(i_mem_rdata))
    else $error("acc load");
  a_acc_hold: assert property (!rx |=> $stable(o_accumulator)) else $error("acc moved");
  a_done_pulse: assert property (rx |=> o_done) else $error("no done");
  a_done_once: assert property (o_done |=> !o_done) else $error("done held");
endmodule
bind load_accumulator_indirect ind_load_chk i_ind_load_chk (.*);

// file: test/test_load_accumulator_indirect.sv
// Purpose: self-checking bench for the indirect load unit
// Assumes: memory answers after a random stall
// Notes: pointer loads while busy must be ignored
`timescale 1ns/1ps
module test_load_accumulator_indirect;
  logic i_clk_sys = '0, i_rst_n = '0, i_start = '0, i_ptr_sel = '0, i_use_offset = '0;
  logic i_ptr_wr = '0, i_ptr_wr_sel = '0, i_mem_valid = '0, o_mem_rd, o_busy, o_done;
  logic [1:0] i_pointer_update_mode = '0;
  logic [5:0] i_offset = '0;
  logic [7:0] i_mem_rdata = '0, o_accumulator;
  logic [15:0] i_ptr_wr_data = '0, o_mem_addr, o_indirect_pointer0, o_indirect_pointer1;
  int compares = 0, miscompares = 0, a, ptr [2];
  always #20 i_clk_sys = ~i_clk_sys;
  load_accumulator_indirect i_load_accumulator_indirect (.*);
  task chk(input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t %h %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task idle;
    for (int n = 0; n < 9 && o_busy !== 1'b0; n++) @(posedge i_clk_sys) #1;
    chk(o_busy, 0);
    if (miscompares > 0) test_done;
  endtask
  task ld(int s, int v);
    idle;
    {i_ptr_wr, i_ptr_wr_sel, i_ptr_wr_data, ptr[s]} = {1'b1, s[0], v[15:0], v};
    @(posedge i_clk_sys) #1;
    i_ptr_wr = '0;
  endtask
  task op(int s, int u, int m, int k, int d, int w);
    idle;
    a = u ? ptr[s] + $signed(k[5:0]) : m[1] ? ptr[s] : ptr[s] + (m[0] ? -1 : 1);
    ptr[s] += u ? 0 : m[0] ? -1 : 1;
    {i_start, i_ptr_sel, i_use_offset} = {1'b1, s[0], u[0]};
    {i_pointer_update_mode, i_offset} = {m[1:0], k[5:0]};
    @(posedge i_clk_sys) #1;
    // Pointer load while busy
    {i_start, i_ptr_wr, i_ptr_wr_data} = {1'b0, 1'b1, ~a[15:0]};
    chk(o_mem_addr, a[15:0]);
    chk(o_mem_rd, 1);
    repeat (w) @(posedge i_clk_sys) #1;
    {i_mem_valid, i_mem_rdata} = {1'b1, d[7:0]};
    @(posedge i_clk_sys) #1;
    {i_ptr_wr, i_mem_valid} = '0;
    chk(o_done, 1);
    chk(o_accumulator, d[7:0]);
    chk(o_indirect_pointer0, ptr[0][15:0]);
    chk(o_indirect_pointer1, ptr[1][15:0]);
  endtask
  initial begin
    void'($urandom(32'h307FFBC8));
    #61 i_rst_n = '1;
    ld(0, 32'h0000FFFF);
    for (int i = 0; i < 4; i++) op(0, 0, i, 0, $urandom, i);
    for (int i = 0; i < 50; i++) begin
      ld($urandom % 2, $urandom);
      op($urandom % 2, $urandom % 2, $urandom % 4, $urandom, $urandom, $urandom % 3);
    end
    test_done;
  end
endmodule
